// ==== core/twbc_host.sv ====
// two-wire bus master outside the device, commanded over apb
// assumes external pull-ups on scl and sda; lines resolved by the bench from the enables
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
`include "twbc_regs.svh"
module twbc_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  twbc_pkg::twbc_state_t state_q, state_d;
  logic ph_q, ph_d, hi_seen_q, hi_seen_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shr_q, shr_d, rx_q, rx_d, txd_q, txd_d;
  logic [15:0] div_q, div_d;
  logic wr_q, wr_d, rnack_q, rnack_d, owner_q, owner_d, busy_q, busy_d;
  logic sda_prev_q, sda_prev_d, sda_drv_q, sda_drv_d, scl_drv_q, scl_drv_d;
  logic done_q, done_d, nack_q, nack_d, arb_q, arb_d, abort_q, abort_d, en_q, en_d;
  logic scl_s, sda_s, tick, clr, wr_en, cmd_go, start_det, stop_det;
  logic fin, lose, done_set, nack_set, arb_set, smp, ends;
  twbc_sync u_scl_sync (.pclk(pclk), .presetn(presetn), .d(scl_i), .q(scl_s));
  twbc_sync u_sda_sync (.pclk(pclk), .presetn(presetn), .d(sda_i), .q(sda_s));
  twbc_tick u_tick (.pclk(pclk), .presetn(presetn), .clr(clr), .div(div_q), .tick(tick));
  assign wr_en = psel & penable & pwrite;
  assign cmd_go = wr_en && (paddr == `TWBC_A_CMD) && (state_q == twbc_pkg::ST_IDLE) && en_q;
  assign start_det = scl_s & sda_prev_q & ~sda_s;
  assign stop_det = scl_s & ~sda_prev_q & sda_s;
  assign pready = 1'b1;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = ~scl_drv_q;
  assign sda_oe_n = ~sda_drv_q;
  // register read mux and unmapped answer
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    unique case (paddr)
      `TWBC_A_CTRL: prdata[`TWBC_CTRL_EN] = en_q;
      `TWBC_A_CMD: prdata = 32'h00000000;
      `TWBC_A_TXD: prdata[7:0] = txd_q;
      `TWBC_A_RXD: prdata[7:0] = rx_q;
      `TWBC_A_STAT: prdata[6:0] = {abort_q, arb_q, nack_q, done_q, owner_q, busy_q, state_q != twbc_pkg::ST_IDLE};
      `TWBC_A_DIV: prdata[15:0] = div_q;
      default: pslverr = psel & penable;
    endcase
  end
  always_comb begin
    state_d = state_q;
    ph_d = ph_q;
    hi_seen_d = hi_seen_q;
    bit_d = bit_q;
    shr_d = shr_q;
    rx_d = rx_q;
    txd_d = txd_q;
    div_d = div_q;
    wr_d = wr_q;
    rnack_d = rnack_q;
    owner_d = owner_q;
    busy_d = busy_q;
    sda_prev_d = sda_s;
    sda_drv_d = sda_drv_q;
    scl_drv_d = scl_drv_q;
    done_d = done_q;
    nack_d = nack_q;
    arb_d = arb_q;
    abort_d = abort_q;
    en_d = en_q;
    clr = 1'b0;
    lose = 1'b0;
    done_set = 1'b0;
    nack_set = 1'b0;
    arb_set = 1'b0;
    smp = 1'b0;
    ends = 1'b0;
    fin = tick & ph_q;
    if (tick && !ph_q) begin
      ph_d = 1'b1;
    end
    if (wr_en) begin
      unique case (paddr)
        `TWBC_A_CTRL: en_d = pwdata[`TWBC_CTRL_EN];
        `TWBC_A_TXD: txd_d = pwdata[7:0];
        `TWBC_A_DIV: div_d = pwdata[15:0];
        `TWBC_A_STAT: begin
          done_d = done_q & ~pwdata[`TWBC_ST_DONE];
          nack_d = nack_q & ~pwdata[`TWBC_ST_NACK];
          arb_d = arb_q & ~pwdata[`TWBC_ST_ARB];
        end
        default: ;
      endcase
    end
    // bus monitor
    if (start_det) begin
      busy_d = 1'b1;
    end
    if (stop_det) begin
      busy_d = 1'b0;
    end
    // states that wait for the real scl high
    if ((state_q == twbc_pkg::ST_BIT_HI || state_q == twbc_pkg::ST_RS_HI || state_q == twbc_pkg::ST_STOP_HI)
        && !hi_seen_q) begin
      clr = 1'b1;
      fin = 1'b0;
      ph_d = 1'b0;
      hi_seen_d = scl_s;
    end
    unique case (state_q)
      twbc_pkg::ST_IDLE: begin
        if (cmd_go) begin
          unique case (pwdata[2:0])
            `TWBC_CMD_START: begin
              if (owner_q) begin
                sda_drv_d = 1'b0;
                abort_d = 1'b0;
                state_d = twbc_pkg::ST_RS_LO;
              end else if (busy_q || !scl_s || !sda_s) begin
                arb_set = 1'b1;
              end else begin
                sda_drv_d = 1'b1;
                owner_d = 1'b1;
                abort_d = 1'b0;
                state_d = twbc_pkg::ST_START;
              end
            end
            `TWBC_CMD_WRITE: begin
              if (owner_q && !abort_q) begin
                shr_d = txd_q;
                wr_d = 1'b1;
                bit_d = 4'h0;
                state_d = twbc_pkg::ST_BIT_LO;
              end
            end
            `TWBC_CMD_READ: begin
              if (owner_q && !abort_q) begin
                wr_d = 1'b0;
                rnack_d = pwdata[`TWBC_CMD_NACK];
                bit_d = 4'h0;
                state_d = twbc_pkg::ST_BIT_LO;
              end
            end
            `TWBC_CMD_STOP: begin
              if (owner_q) begin
                sda_drv_d = 1'b1;
                abort_d = 1'b0;
                state_d = twbc_pkg::ST_STOP_LO;
              end
            end
            default: ;
          endcase
        end
      end
      twbc_pkg::ST_START: begin
        if (fin) begin
          scl_drv_d = 1'b1;
          shr_d = txd_q;
          wr_d = 1'b1;
          bit_d = 4'h0;
          state_d = twbc_pkg::ST_BIT_LO;
        end
      end
      twbc_pkg::ST_RS_LO: begin
        if (fin) begin
          scl_drv_d = 1'b0;
          state_d = twbc_pkg::ST_RS_HI;
        end
      end
      twbc_pkg::ST_RS_HI: begin
        if (fin) begin
          sda_drv_d = 1'b1;
          state_d = twbc_pkg::ST_START;
        end
      end
      twbc_pkg::ST_BIT_LO: begin
        if (tick && !ph_q) begin
          // data or acknowledge driven mid-low
          sda_drv_d = (bit_q != `TWBC_ACK_BIT) ? (wr_q & ~shr_q[7]) : (~wr_q & ~rnack_q);
        end
        if (fin) begin
          scl_drv_d = 1'b0;
          state_d = twbc_pkg::ST_BIT_HI;
        end
      end
      twbc_pkg::ST_BIT_HI: begin
        if (hi_seen_q) begin
          smp = ~ph_q & (tick | ~scl_s);
          ends = fin | ~scl_s;
          if (smp) begin
            ph_d = 1'b1;
            if (bit_q != `TWBC_ACK_BIT) begin
              lose = wr_q & ~sda_drv_q & ~sda_s;
              shr_d = {shr_q[6:0], sda_s};
            end else if (wr_q) begin
              nack_set = sda_s;
              abort_d = sda_s;
            end else begin
              lose = rnack_q & ~sda_s;
            end
          end
          if (lose) begin
            sda_drv_d = 1'b0;
            scl_drv_d = 1'b0;
            owner_d = 1'b0;
            arb_set = 1'b1;
            state_d = twbc_pkg::ST_IDLE;
          end else if (ends) begin
            scl_drv_d = 1'b1;
            if (bit_q == `TWBC_ACK_BIT) begin
              done_set = 1'b1;
              if (!wr_q) begin
                rx_d = shr_q;
              end
              state_d = twbc_pkg::ST_IDLE;
            end else begin
              bit_d = bit_q + 4'h1;
              state_d = twbc_pkg::ST_BIT_LO;
            end
          end
        end
      end
      twbc_pkg::ST_STOP_LO: begin
        if (fin) begin
          scl_drv_d = 1'b0;
          state_d = twbc_pkg::ST_STOP_HI;
        end
      end
      twbc_pkg::ST_STOP_HI: begin
        if (fin) begin
          sda_drv_d = 1'b0;
          state_d = twbc_pkg::ST_STOP_END;
        end
      end
      twbc_pkg::ST_STOP_END: begin
        if (fin) begin
          owner_d = 1'b0;
          state_d = twbc_pkg::ST_IDLE;
        end
      end
    endcase
    if (!en_q) begin
      state_d = twbc_pkg::ST_IDLE;
      sda_drv_d = 1'b0;
      scl_drv_d = 1'b0;
      owner_d = 1'b0;
    end
    if (state_d != state_q) begin
      ph_d = 1'b0;
      hi_seen_d = 1'b0;
      clr = 1'b1;
    end
    done_d = done_d | done_set;
    nack_d = nack_d | nack_set;
    arb_d = arb_d | arb_set;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= twbc_pkg::ST_IDLE;
      ph_q <= 1'b0;
      hi_seen_q <= 1'b0;
      bit_q <= 4'h0;
      shr_q <= 8'h00;
      rx_q <= 8'h00;
      txd_q <= 8'h00;
      div_q <= `TWBC_DIV_RST;
      wr_q <= 1'b0;
      rnack_q <= 1'b0;
      owner_q <= 1'b0;
      busy_q <= 1'b0;
      sda_prev_q <= 1'b1;
      sda_drv_q <= 1'b0;
      scl_drv_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      arb_q <= 1'b0;
      abort_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ph_q <= ph_d;
      hi_seen_q <= hi_seen_d;
      bit_q <= bit_d;
      shr_q <= shr_d;
      rx_q <= rx_d;
      txd_q <= txd_d;
      div_q <= div_d;
      wr_q <= wr_d;
      rnack_q <= rnack_d;
      owner_q <= owner_d;
      busy_q <= busy_d;
      sda_prev_q <= sda_prev_d;
      sda_drv_q <= sda_drv_d;
      scl_drv_q <= scl_drv_d;
      done_q <= done_d;
      nack_q <= nack_d;
      arb_q <= arb_d;
      abort_q <= abort_d;
      en_q <= en_d;
    end
  end
  property p_start_free;
    @(posedge pclk) disable iff (!presetn)
      (state_q == twbc_pkg::ST_IDLE && state_d == twbc_pkg::ST_START) |-> (scl_s && sda_s && !busy_q);
  endproperty
  a_start_free: assert property (p_start_free) else $error("start on a busy bus");
  property p_start_shape;
    @(posedge pclk) disable iff (!presetn)
      (state_q == twbc_pkg::ST_START) |-> (sda_drv_q && !scl_drv_q);
  endproperty
  a_start_shape: assert property (p_start_shape) else $error("start without sda low, scl high");
  property p_stop_shape;
    @(posedge pclk) disable iff (!presetn)
      ($fell(sda_drv_q) && $past(state_q) == twbc_pkg::ST_STOP_HI) |-> (!scl_drv_q && $past(hi_seen_q));
  endproperty
  a_stop_shape: assert property (p_stop_shape) else $error("stop sda rise not under high scl");
  property p_addr_first;
    @(posedge pclk) disable iff (!presetn)
      (state_q == twbc_pkg::ST_START && state_d == twbc_pkg::ST_BIT_LO) |=>
        (wr_q && bit_q == 4'h0 && shr_q == $past(txd_q));
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("address byte not loaded after start");
  property p_sda_low_only;
    @(posedge pclk) disable iff (!presetn)
      ($changed(sda_drv_q) && state_q == twbc_pkg::ST_BIT_LO && $past(state_q) == twbc_pkg::ST_BIT_LO)
        |-> scl_drv_q;
  endproperty
  a_sda_low_only: assert property (p_sda_low_only) else $error("sda changed while scl released");
  property p_nine_clocks;
    @(posedge pclk) disable iff (!presetn)
      (state_q == twbc_pkg::ST_BIT_HI && state_d == twbc_pkg::ST_IDLE && !arb_set) |->
        (bit_q == 4'h8) ##1 (done_q && scl_drv_q);
  endproperty
  a_nine_clocks: assert property (p_nine_clocks) else $error("byte ended off the ninth clock");
  property p_nack_seen;
    @(posedge pclk) disable iff (!presetn)
      (smp && wr_q && bit_q == 4'h8 && sda_s) |=> (nack_q && abort_q);
  endproperty
  a_nack_seen: assert property (p_nack_seen) else $error("missing acknowledge not recorded");
  property p_master_nack;
    @(posedge pclk) disable iff (!presetn)
      (state_q == twbc_pkg::ST_BIT_HI && bit_q == 4'h8 && !wr_q && rnack_q) |-> !sda_drv_q;
  endproperty
  a_master_nack: assert property (p_master_nack) else $error("sda driven on withheld acknowledge");
  property p_abort_block;
    @(posedge pclk) disable iff (!presetn)
      (cmd_go && abort_q && (pwdata[2:0] == `TWBC_CMD_WRITE || pwdata[2:0] == `TWBC_CMD_READ))
        |=> (state_q == twbc_pkg::ST_IDLE);
  endproperty
  a_abort_block: assert property (p_abort_block) else $error("data moved after failed acknowledge");
  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      (cmd_go && owner_q && pwdata[2:0] == `TWBC_CMD_START) |=> (state_q == twbc_pkg::ST_RS_LO && owner_q);
  endproperty
  a_restart: assert property (p_restart) else $error("repeated start lost the bus");
  property p_wait_high;
    @(posedge pclk) disable iff (!presetn)
      (state_q == twbc_pkg::ST_BIT_HI && !hi_seen_q && !scl_s && en_q) |=>
        (state_q == twbc_pkg::ST_BIT_HI && !scl_drv_q);
  endproperty
  a_wait_high: assert property (p_wait_high) else $error("master ran on while scl held low");
endmodule

// ==== core/twbc_regs.svh ====
// register offsets, field positions, reset values and commands of the two-wire bus host
// assumes apb byte addresses in paddr[7:0], one 32-bit word per register
`ifndef TWBC_REGS_SVH
`define TWBC_REGS_SVH
`define TWBC_A_CTRL 8'h00
`define TWBC_A_CMD 8'h04
`define TWBC_A_TXD 8'h08
`define TWBC_A_RXD 8'h0c
`define TWBC_A_STAT 8'h10
`define TWBC_A_DIV 8'h14
`define TWBC_CTRL_EN 0
`define TWBC_CMD_NACK 3
`define TWBC_ST_CBUSY 0
`define TWBC_ST_BUSY 1
`define TWBC_ST_OWNER 2
`define TWBC_ST_DONE 3
`define TWBC_ST_NACK 4
`define TWBC_ST_ARB 5
`define TWBC_ST_ABORT 6
`define TWBC_CMD_START 3'h1
`define TWBC_CMD_WRITE 3'h2
`define TWBC_CMD_READ 3'h3
`define TWBC_CMD_STOP 3'h4
`define TWBC_DIV_RST 16'h0018
`define TWBC_ACK_BIT 4'h8
`endif

// ==== core/twbc_pkg.sv ====
// types of the two-wire bus host
// assumes nothing beyond a systemverilog compiler
package twbc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_RS_LO, ST_RS_HI, ST_BIT_LO, ST_BIT_HI, ST_STOP_LO, ST_STOP_HI, ST_STOP_END
  } twbc_state_t;
endpackage

// ==== core/twbc_sync.sv ====
// two flip-flop synchroniser for one bus line
// assumes an idle-high open-drain line
`timescale 1ns/10ps
module twbc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic meta_q;
  logic meta_d;
  logic q_d;
  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule

// ==== core/twbc_tick.sv ====
// quarter-bit enable divider, restartable
// assumes clr and div come from logic on pclk
`timescale 1ns/10ps
module twbc_tick (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic [15:0] div,
  output logic tick
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  always_comb begin
    tick = (cnt_q == div);
    if (clr || tick) begin
      cnt_d = 16'h0000;
    end else begin
      cnt_d = cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ==== tb/twbc_dev_model.sv ====
// device end of the two-wire bus, answering as an addressed target
// assumes both lines resolved outside from every party's enable, with pull-ups
`timescale 1ns/10ps
module twbc_dev_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2a,
  parameter int STRETCH_NS = 60
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] rd_byte,
  input wire logic ack_en,
  input wire logic slow,
  output logic sda_oe_n,
  output logic scl_oe_n,
  output logic [7:0] got_byte,
  output logic busy
);
  int cnt = 0;
  logic [7:0] sh = 8'h00;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic adr = 1'b0;
  logic mack = 1'b1;
  initial begin
    sda_oe_n = 1'b1;
    scl_oe_n = 1'b1;
    got_byte = 8'h00;
    busy = 1'b0;
  end
  // start or repeated start reopens the address phase
  always @(negedge sda) if (scl === 1'b1) begin
    busy = 1'b1;
    cnt = 0;
    adr = 1'b1;
  end
  // stop frees the bus and drops selection
  always @(posedge sda) if (scl === 1'b1) begin
    busy = 1'b0;
    sel = 1'b0;
    sda_oe_n = 1'b1;
  end
  always @(posedge scl) if (busy) begin
    if (cnt < 8)
      sh = {sh[6:0], sda};
    else
      mack = sda;
    cnt++;
  end
  // sda only changes while scl is low
  always @(negedge scl) if (busy) begin
    if (cnt == 8) begin
      if (adr) begin
        sel = (sh[7:1] == OWN_ADDR);
        rd = sh[0];
      end else if (sel && !rd) begin
        got_byte = sh;
      end
      sda_oe_n = !(sel && (adr || (!rd && ack_en)));
    end else if (cnt == 9) begin
      if (rd && !adr && mack)
        sel = 1'b0;
      adr = 1'b0;
      cnt = 0;
    end
    if (cnt < 8 && !adr)
      sda_oe_n = !(sel && rd) | rd_byte[7 - cnt];
    if (slow) begin
      scl_oe_n = 1'b0;
      #(STRETCH_NS);
      scl_oe_n = 1'b1;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench of the two-wire bus host over apb
// assumes pull-ups on both lines, modelled as the and of every enable
`timescale 1ns/10ps
`include "twbc_regs.svh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic pready, pslverr, slverr;
  logic h_scl_oe_n, h_sda_oe_n, d_scl_oe_n, d_sda_oe_n, d_busy;
  logic h_scl_o, h_sda_o;
  logic riv_n = 1'b1;
  logic ack_en = 1'b1;
  logic slow = 1'b0;
  logic [7:0] rd_byte = 8'h3c;
  logic [7:0] got_byte;
  wire scl = (h_scl_oe_n | h_scl_o) & d_scl_oe_n;
  wire sda = (h_sda_oe_n | h_sda_o) & d_sda_oe_n & riv_n;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  always #2 pclk = ~pclk;
  twbc_host i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
    .scl_o(h_scl_o), .scl_oe_n(h_scl_oe_n), .sda_i(sda), .sda_o(h_sda_o), .sda_oe_n(h_sda_oe_n));
  twbc_dev_model #(.OWN_ADDR(7'h2a)) i_dev (.scl(scl), .sda(sda), .rd_byte(rd_byte), .ack_en(ack_en),
    .slow(slow), .sda_oe_n(d_sda_oe_n), .scl_oe_n(d_scl_oe_n), .got_byte(got_byte), .busy(d_busy));
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      $display("timeout reached");
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // clears sticky flags, issues a command, polls until the engine is idle
  task automatic cmd(input logic [3:0] c);
    apb(1'b1, `TWBC_A_STAT, 32'h38);
    apb(1'b1, `TWBC_A_CMD, {28'h0, c});
    r = 32'h1;
    while (r[0] !== 1'b0) begin
      apb(1'b0, `TWBC_A_STAT, 32'h0);
    end
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `TWBC_A_CTRL, 32'h0);
    chk("ctrl", 32'h0, r);
    apb(1'b0, `TWBC_A_DIV, 32'h0);
    chk("div", 32'h18, r);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, slverr});
    cmd({1'b0, `TWBC_CMD_START});
    chk("status off", 32'h0, r & 32'h7f);
    chk("sda off", 32'h1, {31'h0, h_sda_oe_n});
    chk("drive levels", 32'h0, {30'h0, h_scl_o, h_sda_o});
    $display("test reset finished");
    apb(1'b1, `TWBC_A_CTRL, 32'h1);
    apb(1'b1, `TWBC_A_DIV, 32'h3);
    apb(1'b1, `TWBC_A_TXD, 32'h54);
    apb(1'b0, `TWBC_A_CTRL, 32'h0);
    chk("ctrl set", 32'h1, r);
    apb(1'b0, `TWBC_A_DIV, 32'h0);
    chk("div set", 32'h3, r);
    apb(1'b0, `TWBC_A_TXD, 32'h0);
    chk("txd", 32'h54, r);
    apb(1'b0, `TWBC_A_CMD, 32'h0);
    chk("cmd reads zero", 32'h0, r);
    cmd({1'b0, `TWBC_CMD_START});
    chk("addr ack", 32'h0e, r & 32'h1f);
    chk("scl held", 32'h0, {31'h0, h_scl_oe_n});
    apb(1'b1, `TWBC_A_TXD, 32'ha5);
    slow <= 1'b1;
    cmd({1'b0, `TWBC_CMD_WRITE});
    chk("write stat", 32'h0e, r & 32'h1f);
    chk("byte", 32'ha5, {24'h0, got_byte});
    slow <= 1'b0;
    cmd({1'b0, `TWBC_CMD_STOP});
    chk("stop stat", 32'h0, r & 32'h07);
    chk("dev idle", 32'h0, {31'h0, d_busy});
    $display("test write finished");
    apb(1'b1, `TWBC_A_TXD, 32'h55);
    cmd({1'b0, `TWBC_CMD_START});
    cmd({1'b1, `TWBC_CMD_READ});
    chk("read stat", 32'h0e, r & 32'h0f);
    apb(1'b0, `TWBC_A_RXD, 32'h0);
    chk("rxd", 32'h3c, r);
    apb(1'b1, `TWBC_A_TXD, 32'h54);
    cmd({1'b0, `TWBC_CMD_START});
    chk("restart", 32'h0e, r & 32'h1f);
    apb(1'b1, `TWBC_A_TXD, 32'h77);
    ack_en <= 1'b0;
    cmd({1'b0, `TWBC_CMD_WRITE});
    chk("data nack", 32'h5e, r & 32'h7f);
    ack_en <= 1'b1;
    cmd({1'b0, `TWBC_CMD_STOP});
    apb(1'b1, `TWBC_A_TXD, 32'h60);
    cmd({1'b0, `TWBC_CMD_START});
    chk("addr nack", 32'h5e, r & 32'h7f);
    cmd({1'b0, `TWBC_CMD_WRITE});
    chk("write blocked", 32'h46, r & 32'h7f);
    cmd({1'b0, `TWBC_CMD_STOP});
    chk("stop after nack", 32'h0, r & 32'h7f);
    $display("test read and nack finished");
    riv_n <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b1, `TWBC_A_TXD, 32'hff);
    cmd({1'b0, `TWBC_CMD_START});
    chk("busy refuse", 32'h22, r & 32'h27);
    riv_n <= 1'b1;
    repeat (10) @(posedge pclk);
    fork
      cmd({1'b0, `TWBC_CMD_START});
      begin
        @(negedge scl);
        @(posedge pclk);
        riv_n <= 1'b0;
      end
    join
    chk("arb lost", 32'h22, r & 32'h27);
    chk("lines free", 32'h3, {30'h0, h_scl_oe_n, h_sda_oe_n});
    riv_n <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b1, `TWBC_A_STAT, 32'h20);
    apb(1'b0, `TWBC_A_STAT, 32'h0);
    chk("arb clear", 32'h0, r & 32'h27);
    $display("test arbitration finished");
    print_verdict();
  end
endmodule
